// ===== common/ctr_consts.svh
// Summary of operation
// (RQ1) Preset: reset A clears value and outputs
// (RQ2) Total: reset B clears only total
// (RQ3) Batch: reset B clears batch count, output
// (RQ4) Dual/twin: reset A clears counter A only
// (RQ5) Dual/twin: reset B clears counter B only
// (RQ6) Total: key clears value, total, outputs
// (RQ7) Batch: key clears values and all outputs
// (RQ8) Twin: key clears only the shown counter
// (RQ9) Factory configuration is two-stage or single-stage
// (RQ10) Switches read as all off by default
// (RQ11) Switch 1 off means switches ignored
// (RQ12) Switches sampled only at power-up
// (RQ13) Switch encodings for speed, output, averaging
// (RQ14) Menu does not stop counting or outputs
// (RQ15) Menu edits held until run mode
// (RQ16) Changed settings reinitialise and clear outputs
// (RQ17) Switch items hidden from menu when enabled
// (RQ18) Five tachometer input modes
// (RQ19) Difference, ratio and difference ratio arithmetic
// (RQ20) Second output mode only for two inputs
// (RQ21) Two-input tachometer limits 10 kHz to 5 kHz
// (RQ22) Decimal zero to four, dashes for pulse/seconds
// (RQ23) Switch values latched at reset, then held
// (RQ24) Resets act synchronously within one cycle; the code clears three cycles after the pin, behind two synchroniser flops
`ifndef CTR_CONSTS_SVH
`define CTR_CONSTS_SVH
`define A_CFG     8'h00
`define A_MODE    8'h04
`define A_SETA    8'h08
`define A_SETB    8'h0C
`define A_STAT    8'h10
`define A_PVA     8'h14
`define A_PVB     8'h18
`define A_TOT     8'h1C
`define A_BAT     8'h20
`define A_TACH    8'h24
`define MODE_MENU 0
`define SW_EN     0
`define SW_SPD    1
`define SW_OUT    3:2
`define SW_AVG    5:4
`define PIN_CA    0
`define PIN_CB    1
`define PIN_R1    2
`define PIN_R2    3
`define PIN_KEY   4
`define PIN_SEL   5
`define PIN_SW    13:6
`define PIN_W     14
`define CAP_WAIT  2'h2
`define DP_MAX    3'h4
`define DP_DASH   3'h7
`define RATIO_SH  8
`endif

// ===== common/ctr_pkg.sv
`include "ctr_consts.svh"
package ctr_pkg;
   typedef enum logic [2:0] {CFG_PRESET1, CFG_PRESET2, CFG_TOTAL,
                             CFG_BATCH, CFG_DUAL, CFG_TWIN,
                             CFG_TACH} ctr_sel_e;
   typedef enum logic [2:0] {TIN_SINGLE, TIN_TWO, TIN_DIFF, TIN_RATIO,
                             TIN_DRATIO} ctr_tin_e;
   typedef enum logic [1:0] {OUT_HILO, OUT_RANGE, OUT_HI,
                             OUT_LO} ctr_outm_e;
   typedef enum logic [1:0] {SPD_30HZ, SPD_5K, SPD_10K} ctr_spd_e;
   // Configuration word as software sees it
   typedef struct packed {
      ctr_sel_e  sel;
      ctr_tin_e  tin;
      logic      spd_hi;
      ctr_outm_e outm;
      ctr_outm_e outm2;
      logic [2:0] avg;
      logic [2:0] dp;
      logic      unit_nodp;
   } ctr_cfg_s;
   // Status word: effective settings, outputs, latched switches
   typedef struct packed {
      logic [7:0] rsvd;
      ctr_spd_e   spd;
      ctr_outm_e  outm;
      ctr_outm_e  outm2;
      logic [2:0] avg;
      logic [2:0] dp;
      logic       menu;
      logic       bout;
      logic       out_b;
      logic       out_a;
      logic [7:0] sw;
   } ctr_stat_s;
endpackage : ctr_pkg

// ===== core/ctr_core.sv
`timescale 1ns/100ps
`default_nettype none
`include "ctr_consts.svh"
module ctr_core
   import ctr_pkg::*;
#(
   parameter int unsigned CW           = 16,
   parameter bit          SINGLE_STAGE = 1'b0
) (
   input  wire logic        core_clk,
   input  wire logic        resetn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        count_input_a,
   input  wire logic        count_input_b,
   input  wire logic        reset_in_a,
   input  wire logic        reset_in_b,
   input  wire logic        reset_key_in,
   input  wire logic        shown_second_in,
   input  wire logic [7:0]  cfg_switch,
   output logic             control_output_a,
   output logic             control_output_b,
   output logic             batch_output
);

   typedef struct packed {
      logic [`PIN_W-1:0] s1;
      logic [`PIN_W-1:0] s2;
      logic [`PIN_W-1:0] prev;
      logic [1:0]        cap_cnt;
      logic              cap_done;
      logic [7:0]        sw;
      logic              menu;
      ctr_cfg_s          pend;
      ctr_cfg_s          act;
      logic [CW-1:0]     set_a;
      logic [CW-1:0]     set_b;
      logic [CW-1:0]     pv_a;
      logic [CW-1:0]     pv_b;
      logic [CW-1:0]     total;
      logic [CW-1:0]     batch;
      logic [CW-1:0]     tach;
      logic              out_a;
      logic              out_b;
      logic              bout;
      logic              pready;
      logic              pslverr;
      logic [31:0]       prdata;
   } ctr_state_s;

   // Factory configuration depends on the stage variant
   localparam ctr_cfg_s CFG_RST = '{
      sel: (SINGLE_STAGE ? CFG_PRESET1 : CFG_PRESET2), // RQ9
      tin: TIN_SINGLE, spd_hi: 1'b0, outm: OUT_HILO, outm2: OUT_HILO,
      avg: 3'h0, dp: 3'h0, unit_nodp: 1'b0};
   localparam ctr_state_s ST_RST = '{pend: CFG_RST, act: CFG_RST,
                                     default: '0};

   logic [1:0]    rst_sync_q;
   logic          rst_n;
   ctr_state_s    q;
   ctr_state_s    d;
   ctr_stat_s     stat;
   ctr_cfg_s      cfg_rd;
   ctr_outm_e     eff_outm;
   ctr_outm_e     eff_outm2;
   ctr_spd_e      eff_spd;
   logic [2:0]    eff_avg;
   logic [2:0]    eff_dp;
   logic          sw_on;
   logic          spd_hi;
   logic          ev_a;
   logic          ev_b;
   logic          key_ev;
   logic          r1;
   logic          r2;
   logic          shown_b;
   logic          setup;
   logic          acc_wr;
   logic          mode_wr;
   logic          exit_menu;
   logic          exit_chg;
   logic [CW-1:0] tach_v;

   // Tachometer arithmetic; ratios are fixed point with 8 fraction
   // bits and saturate to all ones when the second input reads zero
   function automatic logic [CW-1:0] tach_calc(ctr_tin_e m,
                                               logic [CW-1:0] a,
                                               logic [CW-1:0] b);
      logic signed [2*CW-1:0] num;
      logic signed [2*CW-1:0] den;
      num = '0;
      den = $signed({{CW{1'b0}}, b});
      tach_calc = a;
      case (m)
         TIN_DIFF: tach_calc = a - b; // RQ19
         TIN_RATIO, TIN_DRATIO: begin
            if (m == TIN_RATIO)
               num = $signed({{CW{1'b0}}, a}); // RQ19
            else
               num = $signed({{CW{a < b}}, CW'(a - b)}); // RQ19
            if (b == '0)
               tach_calc = '1;
            else
               tach_calc = CW'((num <<< `RATIO_SH) / den);
         end
         default: ;
      endcase
   endfunction : tach_calc

   // Limit comparison for one tachometer output
   function automatic logic tach_out(ctr_outm_e m, logic first,
                                     logic [CW-1:0] v,
                                     logic [CW-1:0] hi,
                                     logic [CW-1:0] lo);
      logic [CW-1:0] thr;
      thr = first ? hi : lo;
      case (m)
         OUT_HILO:  tach_out = first ? (v > thr) : (v < thr);
         OUT_RANGE: tach_out = (v >= lo) && (v <= hi);
         OUT_HI:    tach_out = v > thr;
         OUT_LO:    tach_out = v < thr;
         default:   tach_out = 1'b0;
      endcase
   endfunction : tach_out

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn)
         rst_sync_q <= 2'b00;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n = rst_sync_q[1];

   // Pin events from the second synchroniser stage
   assign ev_a    = q.s2[`PIN_CA] & ~q.prev[`PIN_CA];
   assign ev_b    = q.s2[`PIN_CB] & ~q.prev[`PIN_CB];
   assign key_ev  = q.s2[`PIN_KEY] & ~q.prev[`PIN_KEY];
   assign r1      = q.s2[`PIN_R1];
   assign r2      = q.s2[`PIN_R2];
   assign shown_b = q.s2[`PIN_SEL];

   // Effective settings: switches override only when switch 1 is on
   assign sw_on     = q.sw[`SW_EN]; // RQ11
   assign eff_outm  = sw_on ? ctr_outm_e'(q.sw[`SW_OUT]) : q.act.outm; // RQ13
   assign eff_outm2 = (q.act.tin == TIN_TWO) ? q.act.outm2 : eff_outm; // RQ20
   assign eff_avg   = sw_on ? {1'b0, q.sw[`SW_AVG]} : q.act.avg; // RQ13
   assign spd_hi    = sw_on ? q.sw[`SW_SPD] : q.act.spd_hi; // RQ13
   always_comb begin
      if (!spd_hi)
         eff_spd = SPD_30HZ;
      else if (q.act.sel == CFG_TACH && q.act.tin != TIN_SINGLE)
         eff_spd = SPD_5K; // RQ21
      else
         eff_spd = SPD_10K;
   end
   assign eff_dp = q.act.unit_nodp ? `DP_DASH : q.act.dp; // RQ22
   assign tach_v = tach_calc(q.act.tin, q.pv_a, q.pv_b); // RQ18

   // Read views; hidden menu items read as zero
   always_comb begin
      stat       = '0;
      stat.spd   = eff_spd;
      stat.outm  = eff_outm;
      stat.outm2 = eff_outm2;
      stat.avg   = eff_avg;
      stat.dp    = eff_dp;
      stat.menu  = q.menu;
      stat.bout  = q.bout;
      stat.out_b = q.out_b;
      stat.out_a = q.out_a;
      stat.sw    = q.sw;
      cfg_rd     = q.pend;
      if (sw_on) begin
         cfg_rd.spd_hi = 1'b0; // RQ17
         cfg_rd.outm   = OUT_HILO;
         cfg_rd.avg    = 3'h0;
      end
   end

   // Bus phase decode; a write lands only on the accepted access edge
   assign setup     = psel & ~penable;
   assign acc_wr    = psel & penable & q.pready & pwrite & ~q.pslverr;
   assign mode_wr   = acc_wr && paddr == `A_MODE;
   assign exit_menu = mode_wr && q.menu && !pwdata[`MODE_MENU];
   assign exit_chg  = exit_menu && (q.pend != q.act);

   // Next state
   always_comb begin
      d = q;
      d.s1   = {cfg_switch, shown_second_in, reset_key_in, reset_in_b,
                reset_in_a, count_input_b, count_input_a};
      d.s2   = q.s1;
      d.prev = q.s2;

      // Switches caught once after release, then frozen until power-on
      if (!q.cap_done) begin
         if (q.cap_cnt == `CAP_WAIT) begin
            d.sw       = q.s2[`PIN_SW]; // RQ12 RQ23
            d.cap_done = 1'b1;
         end else begin
            d.cap_cnt = q.cap_cnt + 2'h1;
         end
      end

      // Counting runs whether or not the menu is open
      case (q.act.sel) // RQ14
         CFG_PRESET1, CFG_PRESET2, CFG_TOTAL: begin
            if (ev_a) begin
               d.pv_a  = CW'(q.pv_a + 1'b1);
               d.total = CW'(q.total + 1'b1);
            end
            if (d.pv_a >= q.set_a)
               d.out_a = 1'b1;
            if (q.act.sel == CFG_PRESET2) begin
               if (d.pv_a >= q.set_b)
                  d.out_b = 1'b1;
            end else begin
               d.out_b = d.out_a;
            end
         end
         CFG_BATCH: begin
            if (ev_a) begin
               d.pv_a = CW'(q.pv_a + 1'b1);
               if (d.pv_a == q.set_a) begin
                  d.pv_a  = '0;
                  d.batch = CW'(q.batch + 1'b1);
                  d.out_a = 1'b1;
               end
            end
            if (q.set_b != '0 && d.batch >= q.set_b)
               d.bout = 1'b1;
         end
         CFG_DUAL, CFG_TWIN, CFG_TACH: begin
            if (ev_a)
               d.pv_a = CW'(q.pv_a + 1'b1);
            if (ev_b)
               d.pv_b = CW'(q.pv_b + 1'b1);
            if (q.act.sel == CFG_DUAL) begin
               if ((CW+1)'(q.pv_a) + (CW+1)'(q.pv_b) >= (CW+1)'(q.set_a)) begin
                  d.out_a = 1'b1;
                  d.out_b = 1'b1;
               end
            end else if (q.act.sel == CFG_TWIN) begin
               if (q.pv_a >= q.set_a)
                  d.out_a = 1'b1;
               if (q.pv_b >= q.set_b)
                  d.out_b = 1'b1;
            end else begin
               d.tach  = tach_v;
               d.out_a = tach_out(eff_outm, 1'b1, tach_v, q.set_a, q.set_b);
               d.out_b = tach_out(eff_outm2, 1'b0, tach_v, q.set_a, q.set_b);
            end
         end
         default: ;
      endcase

      // Reset routing comes after counting so a clear always wins
      case (q.act.sel) // RQ24
         CFG_PRESET1, CFG_PRESET2, CFG_TOTAL, CFG_BATCH: begin
            if (r1 || key_ev) begin
               d.pv_a  = '0; // RQ1
               d.out_a = 1'b0;
               d.out_b = 1'b0;
            end
            if (q.act.sel == CFG_TOTAL && (r2 || key_ev))
               d.total = '0; // RQ2 RQ6
            if (q.act.sel == CFG_BATCH && (r2 || key_ev)) begin
               d.batch = '0; // RQ3 RQ7
               d.bout  = 1'b0;
            end
         end
         CFG_DUAL, CFG_TWIN: begin
            if (r1)
               d.pv_a = '0; // RQ4
            if (r2)
               d.pv_b = '0; // RQ5
            if (key_ev && q.act.sel == CFG_TWIN) begin
               if (shown_b)
                  d.pv_b = '0; // RQ8
               else
                  d.pv_a = '0; // RQ8
            end else if (key_ev) begin
               d.pv_a  = '0;
               d.pv_b  = '0;
               d.out_a = 1'b0;
               d.out_b = 1'b0;
            end
         end
         default: ;
      endcase

      // Bus answer: decode in setup, ready on the first access edge
      d.pready  = 1'b0;
      d.pslverr = 1'b0;
      if (setup) begin
         d.pready = 1'b1;
         d.prdata = '0;
         case (paddr)
            `A_CFG: begin
               d.prdata  = 32'(cfg_rd);
               d.pslverr = pwrite & ~q.menu;
            end
            `A_MODE: d.prdata = 32'(q.menu);
            `A_SETA: d.prdata = 32'(q.set_a);
            `A_SETB: d.prdata = 32'(q.set_b);
            `A_STAT: begin
               d.prdata  = stat;
               d.pslverr = pwrite;
            end
            `A_PVA, `A_PVB, `A_TOT, `A_BAT, `A_TACH: begin
               d.pslverr = pwrite;
               case (paddr)
                  `A_PVA:  d.prdata = 32'(q.pv_a);
                  `A_PVB:  d.prdata = 32'(q.pv_b);
                  `A_TOT:  d.prdata = 32'(q.total);
                  `A_BAT:  d.prdata = 32'(q.batch);
                  default: d.prdata = 32'(q.tach);
               endcase
            end
            default: d.pslverr = 1'b1;
         endcase
      end

      // Register writes; menu edits only touch the pending copy
      if (acc_wr) begin
         case (paddr)
            `A_CFG: begin
               d.pend = ctr_cfg_s'(pwdata[$bits(ctr_cfg_s)-1:0]); // RQ15
               if (d.pend.sel > CFG_TACH)
                  d.pend.sel = q.pend.sel;
               if (d.pend.tin > TIN_DRATIO)
                  d.pend.tin = q.pend.tin; // RQ18
               if (d.pend.dp > `DP_MAX)
                  d.pend.dp = q.pend.dp; // RQ22
               if (sw_on) begin
                  d.pend.spd_hi = q.pend.spd_hi; // RQ17
                  d.pend.outm   = q.pend.outm;
                  d.pend.avg    = q.pend.avg;
               end
            end
            `A_MODE: begin
               d.menu = pwdata[`MODE_MENU];
               if (!q.menu && pwdata[`MODE_MENU])
                  d.pend = q.act;
            end
            `A_SETA: d.set_a = pwdata[CW-1:0];
            `A_SETB: d.set_b = pwdata[CW-1:0];
            default: ;
         endcase
      end

      // Leaving the menu applies edits; a change restarts measurement
      if (exit_menu)
         d.act = q.pend; // RQ15
      if (exit_chg) begin
         d.pv_a  = '0; // RQ16
         d.pv_b  = '0;
         d.total = '0;
         d.batch = '0;
         d.tach  = '0;
         d.out_a = 1'b0;
         d.out_b = 1'b0;
         d.bout  = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         q <= ST_RST; // RQ10
      else
         q <= d;
   end

   assign prdata           = q.prdata;
   assign pready           = q.pready;
   assign pslverr          = q.pslverr;
   assign control_output_a = q.out_a;
   assign control_output_b = q.out_b;
   assign batch_output     = q.bout;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   property p_rst1_preset;
      (q.act.sel inside {CFG_PRESET1, CFG_PRESET2}) && r1
         |=> q.pv_a == '0 && !q.out_a && !q.out_b;
   endproperty
   a_rst1_preset: assert property (p_rst1_preset) // RQ1
      else $error("reset A did not clear preset counter");
   property p_rst2_total;
      q.act.sel == CFG_TOTAL && r2 |=> q.total == '0;
   endproperty
   a_rst2_total: assert property (p_rst2_total) // RQ2
      else $error("reset B did not clear total");
   property p_rst2_batch;
      q.act.sel == CFG_BATCH && r2 |=> q.batch == '0 ##0 !batch_output;
   endproperty
   a_rst2_batch: assert property (p_rst2_batch) // RQ3
      else $error("reset B did not clear batch");
   property p_rst1_dual;
      (q.act.sel inside {CFG_DUAL, CFG_TWIN}) && r1 |=> q.pv_a == '0;
   endproperty
   a_rst1_dual: assert property (p_rst1_dual) // RQ4
      else $error("reset A did not clear counter A");
   property p_rst2_dual;
      (q.act.sel inside {CFG_DUAL, CFG_TWIN}) && r2 && !key_ev
         |=> q.pv_b == '0 && q.total == $past(q.total);
   endproperty
   a_rst2_dual: assert property (p_rst2_dual) // RQ5
      else $error("reset B did not clear counter B");
   property p_key_total;
      q.act.sel == CFG_TOTAL && key_ev
         |=> q.pv_a == '0 && q.total == '0 && !control_output_a;
   endproperty
   a_key_total: assert property (p_key_total) // RQ6
      else $error("reset key missed total mode clear");
   property p_key_twin;
      q.act.sel == CFG_TWIN && key_ev && shown_b && !r2 && !r1
         && !exit_chg && !ev_a |=> q.pv_b == '0 && $stable(q.pv_a);
   endproperty
   a_key_twin: assert property (p_key_twin) // RQ8
      else $error("reset key cleared wrong twin counter");
   property p_sw_hold;
      q.cap_done |=> $stable(q.sw) [*4];
   endproperty
   a_sw_hold: assert property (p_sw_hold) // RQ12
      else $error("latched switches changed");
   property p_menu_hold;
      q.menu && !mode_wr |=> $stable(q.act);
   endproperty
   a_menu_hold: assert property (p_menu_hold) // RQ15
      else $error("settings applied inside menu");
   property p_exit_clear;
      exit_chg |=> !control_output_a && !control_output_b && q.pv_a == '0;
   endproperty
   a_exit_clear: assert property (p_exit_clear) // RQ16
      else $error("changed settings did not reinitialise");
   property p_speed_cap;
      q.act.sel == CFG_TACH && q.act.tin != TIN_SINGLE && spd_hi
         |-> stat.spd == SPD_5K;
   endproperty
   a_speed_cap: assert property (p_speed_cap) // RQ21
      else $error("two-input speed not limited");
   property p_apb_ready;
      setup |=> pready ##1 !pready;
   endproperty
   a_apb_ready: assert property (p_apb_ready)
      else $error("bus answer not one cycle");

endmodule : ctr_core
`default_nettype wire

// ===== bench/ctr_far_model.sv
`timescale 1ns/100ps
`default_nettype none
module ctr_far_model (
   input  wire logic       core_clk,
   output logic            count_input_a,
   output logic            count_input_b,
   output logic            reset_in_a,
   output logic            reset_in_b,
   output logic            reset_key_in,
   output logic            shown_second_in,
   output logic [7:0]      cfg_switch
);
   logic [1:0] cnt_q;
   logic [2:0] pins_q;
   // Pins packed as vectors so one index picks the line
   assign {count_input_b, count_input_a} = cnt_q;
   assign {reset_key_in, reset_in_b, reset_in_a} = pins_q;
   initial begin
      cnt_q = 2'h0;
      pins_q = 3'h0;
      shown_second_in = 1'b0;
      cfg_switch = 8'h00;
   end
   // Switch 1 kept ON, otherwise the other switches are ignored
   task automatic set_sw(input logic [7:0] v);
      cfg_switch <= v | 8'h01;
   endtask : set_sw
   // Three cycles high and low, above the two-cycle minimum
   task automatic pulses(input logic on_b, input int n);
      repeat (n) begin
         @(posedge core_clk);
         cnt_q[on_b] <= 1'b1;
         repeat (3) @(posedge core_clk);
         cnt_q[on_b] <= 1'b0;
         repeat (2) @(posedge core_clk);
      end
      repeat (5) @(posedge core_clk);
   endtask : pulses
   // Index 0 reset a, 1 reset b, 2 front key; sync delay is waited out
   task automatic strobe(input int idx);
      @(posedge core_clk);
      pins_q[idx] <= 1'b1;
      repeat (4) @(posedge core_clk);
      pins_q[idx] <= 1'b0;
      repeat (6) @(posedge core_clk);
   endtask : strobe
endmodule : ctr_far_model
`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "ctr_consts.svh"
module testbench
   import ctr_pkg::*;
;
   typedef struct packed {
      logic [31:0] ev;
      logic [31:0] msk;
      logic        er;
   } ctr_exp_s;
   localparam logic [31:0] ALL = 32'hFFFF_FFFF;
   logic        core_clk = 1'b0;
   logic        resetn   = 1'b0;
   logic [7:0]  paddr    = 8'h00;
   logic        psel     = 1'b0;
   logic        penable  = 1'b0;
   logic        pwrite   = 1'b0;
   logic [31:0] pwdata   = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready, pslverr;
   logic        ca, cb, ra, rb, rk, shown;
   logic        oa, ob, bo;
   logic [2:0]  pins;
   logic [7:0]  sw;
   logic [7:0]  sw0;
   int          n_errors = 0;
   int          checks_done = 0;
   int          cyc = 0;
   int          seed = 32'h98ca5b5a;
   int          n, m;
   ctr_exp_s    q[$];
   ctr_exp_s    x;

   always #4 core_clk = ~core_clk;

   ctr_core #(.CW(16), .SINGLE_STAGE(1'b0)) dut (
      .core_clk(core_clk), .resetn(resetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .count_input_a(ca), .count_input_b(cb), .reset_in_a(ra),
      .reset_in_b(rb), .reset_key_in(rk), .shown_second_in(shown),
      .cfg_switch(sw), .control_output_a(oa), .control_output_b(ob),
      .batch_output(bo));

   ctr_far_model pm (
      .core_clk(core_clk), .count_input_a(ca), .count_input_b(cb),
      .reset_in_a(ra), .reset_in_b(rb), .reset_key_in(rk),
      .shown_second_in(shown), .cfg_switch(sw));

   task automatic summarize();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : summarize

   // Expectation noted first; the monitor pops it at the access edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [31:0] mk,
                      input logic e);
      q.push_back('{d, mk, e});
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [31:0] mk,
                     input logic [31:0] ev, input logic e = 1'b0);
      apb(1'b0, a, ev, mk, e);
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic e = 1'b0);
      apb(1'b1, a, d, 32'h0000_0000, e);
   endtask : wr

   // Changes go through the menu; leaving it applies them
   task automatic cfg(input ctr_sel_e s);
      wr(`A_MODE, 32'h0000_0001);
      wr(`A_CFG, 32'(s) << 15);
      wr(`A_MODE, 32'h0000_0000);
   endtask : cfg

   // Read data and error taken only where pready is sampled high
   always @(posedge core_clk) begin
      if (psel && penable && pready === 1'b1) begin
         x = q.pop_front();
         checks_done++;
         if ((prdata & x.msk) !== (x.ev & x.msk) || pslverr !== x.er) begin
            n_errors++;
            $display("unexpected at %0t: got %h/%h exp %h/%h", $time,
                     prdata & x.msk, pslverr, x.ev & x.msk, x.er);
         end
         // Output pins must match the status bits expected of them
         pins = ({bo, ob, oa} ^ x.ev[10:8]) & x.msk[10:8];
         if (paddr == `A_STAT && pins !== 3'h0) begin
            n_errors++;
            $display("unexpected pins at %0t: got %h exp %h", $time,
                     {bo, ob, oa}, x.ev[10:8]);
         end
      end
   end

   // Guards against a hung handshake
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         summarize();
      end
   end

   initial begin
      sw0 = 8'($random(seed)) | 8'h01;
      pm.set_sw(sw0);
      repeat (10) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (12) @(posedge core_clk);
      pm.set_sw(~sw0);
      rd(`A_CFG, 32'h0003_8000, 32'(CFG_PRESET2) << 15);
      rd(`A_STAT, 32'h0000_00FF, 32'(sw0));
      rd(8'h30, ALL, 32'h0000_0000, 1'b1);
      wr(`A_CFG, 32'h0000_0000, 1'b1);
      wr(`A_SETA, 32'h0000_00FF);
      wr(`A_SETB, 32'h0000_00FF);
      // Both preset kinds: secondary reset ignored, primary clears
      for (int s = 0; s < 2; s++) begin
         n = ($random(seed) & 3) + 1;
         cfg(ctr_sel_e'(s));
         wr(`A_SETA, n);
         pm.pulses(1'b0, n);
         pm.strobe(1);
         rd(`A_PVA, ALL, n);
         rd(`A_STAT, 32'h0000_0300,
            s ? 32'h0000_0100 : 32'h0000_0300);
         pm.strobe(0);
         rd(`A_PVA, ALL, 0);
         rd(`A_STAT, 32'h0000_0300, 0);
      end
      n = ($random(seed) & 3) + 1;
      cfg(CFG_TOTAL);
      pm.pulses(1'b0, n);
      pm.strobe(1);
      rd(`A_TOT, ALL, 0);
      rd(`A_PVA, ALL, n);
      pm.pulses(1'b0, n);
      pm.strobe(2);
      rd(`A_PVA, ALL, 0);
      rd(`A_TOT, ALL, 0);
      rd(`A_STAT, 32'h0000_0300, 0);
      // A count of one per batch, so the batch count tracks the pulses
      cfg(CFG_BATCH);
      wr(`A_SETA, 32'h0000_0001);
      wr(`A_SETB, 32'h0000_0001);
      pm.pulses(1'b0, n);
      rd(`A_STAT, 32'h0000_0700, 32'h0000_0500);
      pm.strobe(1);
      rd(`A_BAT, ALL, 0);
      rd(`A_STAT, 32'h0000_0700, 32'h0000_0100);
      pm.pulses(1'b0, n);
      rd(`A_BAT, ALL, n);
      pm.strobe(2);
      rd(`A_PVA, ALL, 0);
      rd(`A_BAT, ALL, 0);
      rd(`A_STAT, 32'h0000_0700, 0);
      // Dual and twin: each reset reaches its own counter only
      for (int s = CFG_DUAL; s <= CFG_TWIN; s++) begin
         n = ($random(seed) & 3) + 1;
         m = ($random(seed) & 3) + 1;
         cfg(ctr_sel_e'(s));
         pm.pulses(1'b0, n);
         pm.pulses(1'b1, m);
         pm.strobe(0);
         rd(`A_PVA, ALL, 0);
         rd(`A_PVB, ALL, m);
         pm.pulses(1'b0, n);
         pm.strobe(1);
         rd(`A_PVB, ALL, 0);
         rd(`A_PVA, ALL, n);
      end
      pm.pulses(1'b1, m);
      pm.shown_second_in <= 1'b1;
      pm.strobe(2);
      rd(`A_PVB, ALL, 0);
      rd(`A_PVA, ALL, n);
      // Menu keeps counting; a real change clears on the way out
      cfg(CFG_PRESET1);
      wr(`A_MODE, 32'h0000_0001);
      pm.pulses(1'b0, n);
      rd(`A_PVA, ALL, n);
      wr(`A_CFG, 32'(CFG_TOTAL) << 15);
      rd(`A_STAT, 32'h0000_0800, 32'h0000_0800);
      rd(`A_PVA, ALL, n);
      wr(`A_MODE, 32'h0000_0000);
      rd(`A_PVA, ALL, 0);
      rd(`A_CFG, 32'h0003_8000, 32'(CFG_TOTAL) << 15);
      // Difference tachometer; two inputs cap the fast speed
      wr(`A_MODE, 32'h0000_0001);
      wr(`A_CFG, 32'(CFG_TACH) << 15 | 32'(TIN_DIFF) << 12);
      wr(`A_MODE, 32'h0000_0000);
      pm.pulses(1'b1, m);
      pm.pulses(1'b0, n + m);
      rd(`A_TACH, ALL, n);
      rd(`A_STAT, 32'h00C0_0000, 32'(sw0[1]) << 22);
      summarize();
   end
endmodule : testbench
`default_nettype wire
